// ==== rtl/atx_pkg.sv ====
// constants and types shared by the add-two execute block
//----------------------------------------------------------
// Overview of operation
// RULE1: decode file form by fixed opcode prefix
// RULE2: file address spans zero through 8191
// RULE3: read file operand, add two, deliver sum
// RULE4: direction bit zero to work reg, else memory
// RULE5: width bit zero word, one byte
// RULE6: update digit carry, sign, excess, zero, carry
// RULE7: decode register form, destination mode and number
// RULE8: fetch source, add two, store to destination
// RULE9: one instruction word, one instruction cycle
// RULE10: slow special registers may stretch the cycle
// RULE11: default work register is register zero
// RULE12: byte ops touch one byte; pointers step 1/2
//----------------------------------------------------------
package atx_pkg;
    // opcode prefixes, bits 23..15
    localparam logic [8:0] OPC_FILE = 9'h1d9;
    localparam logic [8:0] OPC_WFORM = 9'h1d1;
    // field positions
    localparam int OPC_LSB = 15;
    localparam int BYTE_BIT = 14;
    localparam int DIR_BIT = 13;
    localparam int FADR_W = 13;
    localparam int DMOD_LSB = 11;
    localparam int DREG_LSB = 7;
    localparam int SMOD_LSB = 4;
    localparam int SREG_LSB = 0;
    // arithmetic constants
    localparam logic [15:0] ADD_K = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    // status word image flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_AX = 2;
    localparam int FLG_N = 3;
    localparam int FLG_DGC = 8;
    // register offsets on the bus
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_INFO = 12'h008;
    localparam logic [5:0] OFS_WWIN = 6'h01;
    // reset values
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic CTRL_HALT_RST = 1'b0;
    localparam logic [15:0] W_RST = 16'h0000;
    // addressing modes
    typedef enum logic [2:0] {
        AM_DIRECT = 3'b000,
        AM_IND = 3'b001,
        AM_POST_DEC = 3'b010,
        AM_POST_INC = 3'b011,
        AM_PRE_DEC = 3'b100,
        AM_PRE_INC = 3'b101
    } atx_mode_e;
    // execute sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10,
        ST_WRITE = 2'b11
    } atx_st_e;
endpackage

// ==== rtl/atx_alu.sv ====
// add-two adder with status flag generation
`timescale 1ns/100ps
module atx_alu import atx_pkg::*; (
    // operand
    input wire logic [15:0] opnd,
    input wire logic byte_op,
    // result and flags
    output logic [15:0] res,
    output logic fc,
    output logic fz,
    output logic fov,
    output logic fn,
    output logic fdc
);
    logic [16:0] sw;
    logic [8:0] sb;
    logic [4:0] sn;

    // both widths computed, width bit picks
    assign sw = {1'b0, opnd} + {1'b0, ADD_K};
    assign sb = {1'b0, opnd[7:0]} + {1'b0, ADD_K[7:0]};
    assign sn = {1'b0, opnd[3:0]} + {1'b0, ADD_K[3:0]};

    // flags follow selected width
    always_comb begin
        fdc = sn[4]; // see RULE6
        if (byte_op) begin
            res = {opnd[15:8], sb[7:0]}; // see RULE12
            fc = sb[8];
            fz = (sb[7:0] == 8'h00);
            fn = sb[7];
            fov = ~opnd[7] & sb[7]; // adding positive two
        end else begin
            res = sw[15:0];
            fc = sw[16];
            fz = (sw[15:0] == 16'h0000);
            fn = sw[15];
            fov = ~opnd[15] & sw[15];
        end
    end
endmodule // atx_alu

// ==== rtl/atx_agu.sv ====
// address generator for direct and indirect operands
`timescale 1ns/100ps
module atx_agu import atx_pkg::*; (
    // request
    input wire logic [2:0] mode,
    input wire logic [15:0] ptr,
    input wire logic byte_op,
    // address and pointer update
    output logic [15:0] ea,
    output logic [15:0] ptr_new,
    output logic upd,
    output logic is_reg
);
    logic [15:0] step;

    // pointers move by the operand size
    assign step = byte_op ? STEP_BYTE : STEP_WORD; // see RULE12

    // mode decode; reserved codes act as plain indirect
    always_comb begin
        ea = ptr;
        ptr_new = ptr;
        upd = 1'b0;
        is_reg = 1'b0;
        unique case (atx_mode_e'(mode))
            AM_DIRECT: is_reg = 1'b1;
            AM_IND: upd = 1'b0;
            AM_POST_DEC: begin
                ptr_new = ptr - step;
                upd = 1'b1;
            end
            AM_POST_INC: begin
                ptr_new = ptr + step;
                upd = 1'b1;
            end
            AM_PRE_DEC: begin
                ptr_new = ptr - step;
                ea = ptr - step;
                upd = 1'b1;
            end
            AM_PRE_INC: begin
                ptr_new = ptr + step;
                ea = ptr + step;
                upd = 1'b1;
            end
            default: upd = 1'b0;
        endcase
    end
endmodule // atx_agu

// ==== rtl/atx_exec.sv ====
// add-two instruction decode and execute unit with bus registers
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module atx_exec import atx_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // instruction stream
    input wire logic ins_valid,
    input wire logic [23:0] ins_word,
    output logic ins_ready,
    output logic ins_done,
    output logic ins_illegal,
    // data memory port
    output logic [15:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output logic [1:0] dm_be,
    output logic [15:0] dm_wdata,
    input wire logic [15:0] dm_rdata,
    input wire logic dm_ack,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    //------------------------------------------------------
    // state
    //------------------------------------------------------
    typedef struct packed {
        atx_st_e st;
        logic [15:0][15:0] w;
        logic [15:0] stat;
        logic halt;
        logic [15:0] cnt;
        logic [15:0] opnd;
        logic [23:0] ins;
        logic ins_rdy;
        logic done;
        logic illegal;
        logic [15:0] dm_addr;
        logic [15:0] dm_wdata;
        logic [1:0] dm_be;
        logic dm_rd;
        logic dm_wr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } atx_core_s;

    atx_core_s q;
    atx_core_s n;

    //------------------------------------------------------
    // helpers
    //------------------------------------------------------
    function automatic logic is_file(logic [23:0] i);
        return i[23:OPC_LSB] == OPC_FILE;
    endfunction

    function automatic logic is_wform(logic [23:0] i);
        return i[23:OPC_LSB] == OPC_WFORM;
    endfunction

    // pick the addressed byte lane of a read
    function automatic logic [15:0] lane_rd(logic [15:0] d,
            logic odd, logic b);
        if (!b) begin
            return d;
        end
        return {8'h00, odd ? d[15:8] : d[7:0]};
    endfunction

    // byte ops leave the other byte of a register alone
    function automatic logic [15:0] merge(logic [15:0] old,
            logic [15:0] r, logic b);
        return b ? {old[15:8], r[7:0]} : r;
    endfunction

    logic b_cur;
    logic [3:0] s_idx;
    logic [3:0] d_idx;
    logic [15:0] res;
    logic fc, fz, fov, fn, fdc;
    logic [15:0] s_ea, s_new, d_ea, d_new;
    logic s_upd, s_reg, d_upd, d_reg;
    logic [15:0] d_ptr;
    logic bus_hit;
    logic [31:0] bus_rd;

    assign b_cur = q.ins[BYTE_BIT];
    assign s_idx = ins_word[SREG_LSB +: 4];
    assign d_idx = q.ins[DREG_LSB +: 4];
    // destination pointer sees any source pointer update
    assign d_ptr = q.w[d_idx];

    // adder with flags
    atx_alu u_alu (
        .opnd(q.opnd),
        .byte_op(b_cur),
        .res(res),
        .fc(fc),
        .fz(fz),
        .fov(fov),
        .fn(fn),
        .fdc(fdc)
    );

    // source operand address from the incoming word
    atx_agu u_src (
        .mode(ins_word[SMOD_LSB +: 3]),
        .ptr(q.w[s_idx]),
        .byte_op(ins_word[BYTE_BIT]),
        .ea(s_ea),
        .ptr_new(s_new),
        .upd(s_upd),
        .is_reg(s_reg)
    );

    // destination address from the held word
    atx_agu u_dst (
        .mode(q.ins[DMOD_LSB +: 3]),
        .ptr(d_ptr),
        .byte_op(b_cur),
        .ea(d_ea),
        .ptr_new(d_new),
        .upd(d_upd),
        .is_reg(d_reg)
    );

    //------------------------------------------------------
    // bus read mux
    //------------------------------------------------------
    always_comb begin
        bus_hit = 1'b1;
        bus_rd = 32'h0000_0000;
        if (paddr[11:6] == OFS_WWIN && paddr[1:0] == 2'b00) begin
            bus_rd = {16'h0000, q.w[paddr[5:2]]};
        end else if (paddr == OFS_CTRL) begin
            bus_rd = {31'h0000_0000, q.halt};
        end else if (paddr == OFS_STAT) begin
            bus_rd = {16'h0000, q.stat};
        end else if (paddr == OFS_INFO) begin
            bus_rd = {q.cnt, 14'h0000, q.st};
        end else begin
            bus_hit = 1'b0;
        end
    end

    //------------------------------------------------------
    // next state
    //------------------------------------------------------
    always_comb begin
        n = q;
        n.done = 1'b0;
        n.illegal = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        // one wait cycle, write lands on the completing edge
        if (psel && penable && !q.pready) begin
            n.pready = 1'b1;
            n.prdata = bus_rd;
            n.pslverr = ~bus_hit;
        end
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            if (paddr == OFS_CTRL) begin
                n.halt = pwdata[0];
            end else if (paddr == OFS_STAT) begin
                n.stat = pwdata[15:0];
            end
        end
        unique case (q.st)
            ST_IDLE: begin
                if (q.ins_rdy && ins_valid) begin
                    n.ins = ins_word;
                    if (is_file(ins_word)) begin // see RULE1
                        // full 13-bit near space, zero extended
                        n.dm_addr = {3'b000, ins_word[FADR_W-1:0]}; // see RULE2
                        n.dm_rd = 1'b1; // see RULE3
                        n.st = ST_READ;
                    end else if (is_wform(ins_word)) begin // see RULE7
                        if (s_reg) begin
                            n.opnd = lane_rd(q.w[s_idx], 1'b0,
                                ins_word[BYTE_BIT]); // see RULE8
                            n.st = ST_EXEC;
                        end else begin
                            n.dm_addr = s_ea;
                            n.dm_rd = 1'b1;
                            n.st = ST_READ;
                            if (s_upd) begin
                                n.w[s_idx] = s_new; // see RULE12
                            end
                        end
                    end else begin
                        // not ours; consumed and flagged
                        n.illegal = 1'b1;
                        n.done = 1'b1;
                    end
                end
            end
            ST_READ: begin
                // slow special registers simply hold off the ack
                if (dm_ack) begin // see RULE10
                    n.dm_rd = 1'b0;
                    n.opnd = lane_rd(dm_rdata, q.dm_addr[0], b_cur); // see RULE5
                    n.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                n.stat[FLG_C] = fc; // see RULE6
                n.stat[FLG_Z] = fz;
                n.stat[FLG_AX] = fov;
                n.stat[FLG_N] = fn;
                n.stat[FLG_DGC] = fdc;
                n.cnt = q.cnt + 16'h0001;
                n.st = ST_IDLE;
                n.done = 1'b1; // see RULE9
                if (is_file(q.ins)) begin
                    if (!q.ins[DIR_BIT]) begin // see RULE4
                        n.w[0] = merge(q.w[0], res, b_cur); // see RULE11
                    end else begin
                        n.dm_wr = 1'b1;
                        n.st = ST_WRITE;
                        n.done = 1'b0;
                    end
                end else if (d_reg) begin
                    n.w[d_idx] = merge(q.w[d_idx], res, b_cur); // see RULE8
                end else begin
                    n.dm_addr = d_ea;
                    n.dm_wr = 1'b1;
                    n.st = ST_WRITE;
                    n.done = 1'b0;
                    if (d_upd) begin
                        n.w[d_idx] = d_new;
                    end
                end
                // byte writes replicate data and strobe one lane
                n.dm_wdata = b_cur ? {res[7:0], res[7:0]} : res;
                n.dm_be = !b_cur ? 2'b11 :
                    (n.dm_addr[0] ? 2'b10 : 2'b01); // see RULE12
            end
            ST_WRITE: begin
                if (dm_ack) begin
                    n.dm_wr = 1'b0;
                    n.done = 1'b1;
                    n.st = ST_IDLE;
                end
            end
        endcase
        n.ins_rdy = (n.st == ST_IDLE) && !n.halt;
    end

    // single register stage; ce freezes everything
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    //------------------------------------------------------
    // outputs
    //------------------------------------------------------
    assign ins_ready = q.ins_rdy;
    assign ins_done = q.done;
    assign ins_illegal = q.illegal;
    assign dm_addr = q.dm_addr;
    assign dm_rd = q.dm_rd;
    assign dm_wr = q.dm_wr;
    assign dm_be = q.dm_be;
    assign dm_wdata = q.dm_wdata;
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    //------------------------------------------------------
    // assertions
    //------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !ce);

    logic take;
    logic ex_file;
    assign take = q.ins_rdy && ins_valid;
    assign ex_file = q.st == ST_EXEC && is_file(q.ins);

    a_bad_opcode: assert property ( // see RULE1
        take && !is_file(ins_word) && !is_wform(ins_word)
        |=> q.illegal && q.done && q.st == ST_IDLE)
        else $error("unknown opcode not flagged");
    a_file_addr: assert property ( // see RULE2
        take && is_file(ins_word)
        |=> q.dm_rd && q.dm_addr == {3'b000, $past(ins_word[12:0])})
        else $error("file operand address wrong");
    a_mem_sum: assert property ( // see RULE4
        ex_file && q.ins[DIR_BIT] && !b_cur
        |=> q.dm_wr && q.dm_be == 2'b11
        && q.dm_wdata == $past(q.opnd) + 16'h0002)
        else $error("memory sum wrong");
    a_w0_dest: assert property ( // see RULE11
        ex_file && !q.ins[DIR_BIT] && !b_cur
        |=> q.w[0] == $past(q.opnd) + 16'h0002 && !q.dm_wr)
        else $error("work register zero sum wrong");
    a_byte_keep: assert property ( // see RULE5
        ex_file && !q.ins[DIR_BIT] && b_cur
        |=> q.w[0][15:8] == $past(q.w[0][15:8])
        && q.w[0][7:0] == $past(q.opnd[7:0]) + 8'h02)
        else $error("byte op touched high byte");
    a_zero_carry: assert property ( // see RULE6
        q.st == ST_EXEC && !b_cur
        |=> q.stat[FLG_Z] == ($past(q.opnd) == 16'hfffe)
        && q.stat[FLG_C] == ($past(q.opnd) >= 16'hfffe))
        else $error("word zero or carry flag wrong");
    a_reg_cycle: assert property ( // see RULE9
        take && is_wform(ins_word) && ins_word[6:4] == 3'b000
        && ins_word[13:11] == 3'b000 |-> ##2 q.done)
        else $error("register form not done in time");
    a_read_wait: assert property ( // see RULE10
        q.st == ST_READ && !dm_ack
        |=> q.st == ST_READ && q.dm_rd && !q.done)
        else $error("read dropped before ack");
    a_ptr_step: assert property ( // see RULE12
        take && is_wform(ins_word) && ins_word[6:4] == 3'b011
        |=> q.w[$past(s_idx)] == $past(q.w[s_idx])
        + ($past(ins_word[14]) ? 16'h0001 : 16'h0002))
        else $error("post increment step wrong");

    c_file_mem: cover property (ex_file && q.ins[DIR_BIT] ##1 q.dm_wr);
    c_byte_ind: cover property (take && is_wform(ins_word)
        && ins_word[14] && ins_word[13:11] == 3'b101);
    c_slow_read: cover property (q.st == ST_READ && !dm_ack [*3]);
endmodule // atx_exec

// ==== verification/atx_exec_tb.sv ====
// self-checking bench for the add-two execute unit
`timescale 1ns/100ps
module atx_exec_tb import atx_pkg::*; ;
    //----------------------------------------------------------
    // signals and bench state
    //----------------------------------------------------------
    logic ref_clk, rst_n, ce, ins_valid, ins_ready, ins_done, ins_illegal;
    logic [23:0] ins_word;
    logic [15:0] dm_addr, dm_wdata, dm_rdata;
    logic dm_rd, dm_wr, dm_ack;
    logic [1:0] dm_be;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    int miscompares = 0;
    int cmp_count = 0;
    int wt = 0;
    int nret = 0;
    logic [31:0] seed = 32'h0000_0026;
    logic [15:0] mem [0:32767];
    logic [15:0] w_m [16];
    logic [15:0] stat_m;
    logic [33:0] wq [$];

    atx_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .ins_valid(ins_valid), .ins_word(ins_word), .ins_ready(ins_ready),
        .ins_done(ins_done), .ins_illegal(ins_illegal), .dm_addr(dm_addr),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_be(dm_be), .dm_wdata(dm_wdata),
        .dm_rdata(dm_rdata), .dm_ack(dm_ack), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 200 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    //----------------------------------------------------------
    // helpers
    //----------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed;
    endfunction

    task automatic chk(input logic [63:0] g, x, input string m);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, g, x);
        end
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // memory side: random wait, lane-masked writes, junk data when idle
    always @(posedge ref_clk) begin
        if (dm_ack) begin
            dm_ack <= 1'b0;
            wt = int'(rnd() % 4);
        end else if ((dm_rd || dm_wr) && wt != 0) begin
            wt--;
        end else if (dm_rd || dm_wr) begin
            dm_ack <= 1'b1;
            if (dm_rd) begin
                dm_rdata <= mem[dm_addr[15:1]];
            end else begin
                if (wq.size() == 0) chk(1, 0, "stray write");
                else chk({dm_addr, dm_be, dm_wdata}, wq.pop_front(), "write");
                if (dm_be[0]) mem[dm_addr[15:1]][7:0] = dm_wdata[7:0];
                if (dm_be[1]) mem[dm_addr[15:1]][15:8] = dm_wdata[15:8];
            end
        end
        if (!dm_ack && !(dm_rd && wt == 0)) dm_rdata <= 16'(rnd());
    end

    //----------------------------------------------------------
    // reference model of one instruction
    //----------------------------------------------------------
    function automatic logic [15:0] agu(input logic [2:0] m,
                                        input logic [3:0] n, input logic b);
        logic [15:0] st;
        st = b ? 16'h0001 : 16'h0002;
        if (m == 3'd4) w_m[n] -= st;
        if (m == 3'd5) w_m[n] += st;
        agu = w_m[n];
        if (m == 3'd2) w_m[n] -= st;
        if (m == 3'd3) w_m[n] += st;
    endfunction

    function automatic logic [15:0] rdm(input logic [15:0] ea, input logic b);
        logic [15:0] v;
        v = mem[ea[15:1]];
        return b ? {8'h00, ea[0] ? v[15:8] : v[7:0]} : v;
    endfunction

    // returns expected done latency: 1 illegal, 2 register direct, 0 unknown
    task automatic model(input logic [23:0] iw, output int lat);
        logic b, isf, n;
        logic [15:0] a, r, ea;
        logic [16:0] s;
        logic [3:0] t;
        isf = iw[23:OPC_LSB] == OPC_FILE;
        lat = (isf || iw[23:OPC_LSB] == OPC_WFORM) ? 0 : 1;
        if (lat == 1) return;
        b = iw[BYTE_BIT];
        if (isf) a = rdm({3'b000, iw[FADR_W-1:0]}, b);
        else if (iw[SMOD_LSB+:3] == 3'd0)
            a = b ? {8'h00, w_m[iw[3:0]][7:0]} : w_m[iw[3:0]];
        else a = rdm(agu(iw[SMOD_LSB+:3], iw[3:0], b), b);
        s = (b ? {9'h000, a[7:0]} : {1'b0, a}) + 17'h0_0002;
        r = b ? {8'h00, s[7:0]} : s[15:0];
        n = b ? r[7] : r[15];
        stat_m[FLG_C] = b ? s[8] : s[16];
        stat_m[FLG_Z] = b ? r[7:0] == 8'h00 : r == 16'h0000;
        stat_m[FLG_N] = n;
        stat_m[FLG_AX] = n && !(b ? a[7] : a[15]);
        stat_m[FLG_DGC] = a[3:0] > 4'hd;
        if (isf ? !iw[DIR_BIT] : iw[DMOD_LSB+:3] == 3'd0) begin
            t = isf ? 4'h0 : iw[DREG_LSB+:4];
            w_m[t] = b ? {w_m[t][15:8], r[7:0]} : r;
            if (!isf && iw[SMOD_LSB+:3] == 3'd0) lat = 2;
        end else begin
            ea = isf ? {3'b000, iw[12:0]} : agu(iw[DMOD_LSB+:3], iw[10:7], b);
            wq.push_back({ea, b ? (ea[0] ? 2'b10 : 2'b01) : 2'b11,
                          b ? {2{r[7:0]}} : r});
        end
    endtask

    //----------------------------------------------------------
    // bus and instruction drivers
    //----------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= rnd();
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x, "read data");
        chk(e, ex, "read error");
    endtask

    task automatic regs;
        for (int n = 0; n < 16; n++)
            rd({OFS_WWIN, 4'(n), 2'b00}, {16'h0000, w_m[n]}, 1'b0);
        rd(OFS_STAT, {16'h0000, stat_m}, 1'b0);
    endtask

    // offer one word, time its retirement, then compare registers and status
    task automatic run(input logic [23:0] iw);
        int lat, n;
        model(iw, lat);
        ins_word <= iw;
        ins_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ins_ready !== 1'b1);
        ins_valid <= 1'b0;
        ins_word <= 24'(rnd());
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ins_done !== 1'b1);
        if (lat != 0) chk(n, lat, "latency");
        if (lat != 1) nret++;
        chk(ins_illegal, lat == 1, "illegal flag");
        chk(wq.size(), 0, "missing write");
        regs();
    endtask

    //----------------------------------------------------------
    // main sequence
    //----------------------------------------------------------
    initial begin
        logic [31:0] v, q;
        logic e;
        rst_n = 1'b0;
        ce = 1'b1;
        {ins_valid, ins_word, dm_ack, dm_rdata} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        stat_m = 16'h0000;
        for (int i = 0; i < 16; i++) w_m[i] = 16'h0000;
        for (int i = 0; i < 32768; i++) mem[i] = 16'(rnd());
        mem[16'h0800] = 16'h8fff;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(OFS_CTRL, 32'h0000_0000, 1'b0);
        rd(OFS_INFO, 32'h0000_0000, 1'b0);
        rd(12'h00c, 32'h0000_0000, 1'b1);
        rd(12'h002, 32'h0000_0000, 1'b1);
        regs();
        // status image is writable; flags later overwritten by execution
        v = rnd();
        apb(1'b1, OFS_STAT, v, q, e);
        stat_m = v[15:0];
        rd(OFS_STAT, {16'h0000, stat_m}, 1'b0);
        // halted: an offered word must be neither taken nor retired
        apb(1'b1, OFS_CTRL, 32'h0000_0001, q, e);
        rd(OFS_CTRL, 32'h0000_0001, 1'b0);
        ins_word <= {OPC_WFORM, 15'h0000};
        ins_valid <= 1'b1;
        repeat (6) begin
            @(posedge ref_clk);
            chk({ins_ready, ins_done}, 0, "halt");
        end
        ins_valid <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0000, q, e);
        // enable low: a ready unit must not take an offered word
        ce <= 1'b0;
        ins_word <= 24'h00_0000;
        ins_valid <= 1'b1;
        repeat (4) begin
            @(posedge ref_clk);
            chk({ins_ready, ins_done}, 2'b10, "frozen");
        end
        ce <= 1'b1;
        // file form: word/byte, both destinations, address limits
        run({OPC_FILE, 2'b00, 13'h1000});
        for (int j = 0; j < 8; j++)
            run({OPC_FILE, 2'(j), j[2] ? 13'h1fff : 13'h0000});
        // register form: every addressing mode on each side
        for (int j = 0; j < 16; j++) begin
            run({OPC_WFORM, j[3], 7'h03, j[2:0], 4'h1});
            run({OPC_WFORM, j[3], j[2:0], 4'h2, 7'h01});
        end
        // random mix including undecodable words
        for (int j = 0; j < 150; j++) begin
            v = rnd();
            if (v[31:30] == 2'd0) run(v[23:0]);
            else if (v[31:30] == 2'd1) run({OPC_FILE, v[16:2]});
            else run({OPC_WFORM, v[16:2]});
        end
        // retired count in the info word, sequencer back at idle
        rd(OFS_INFO, {16'(nret), 16'h0000}, 1'b0);
        test_done();
    end

    // hang guard, well beyond the expected run length
    initial begin
        #(60000 * 5);
        miscompares++;
        test_done();
    end
endmodule // atx_exec_tb
